// >>> rtl/tcm_channel_mode_ctrl.sv
module tcm_channel_mode_ctrl
    import tcm_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              RST,
    // register port
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [DATA_W-1:0] REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [DATA_W-1:0] REG_RDATA,
    // timebase from the counter, same clock
    input  wire logic [CNT_W-1:0]  COUNTER_VALUE,
    input  wire logic              COUNT_DIRECTION,
    input  wire logic              OVERFLOW_EVENT,
    input  wire logic              TRIGGER_EVENT,
    input  wire logic              INTERNAL_TRIGGER_INPUT,
    // pins and filtered pin paths, asynchronous
    input  wire logic              FILTERED_PIN1_TO_CH1,
    input  wire logic              FILTERED_PIN2_TO_CH1,
    input  wire logic              FILTERED_PIN2_TO_CH2,
    input  wire logic              FILTERED_PIN1_TO_CH2,
    input  wire logic              EXTERNAL_TRIGGER_INPUT,
    // channel results
    output logic                   CH1_RAW_OUTPUT,
    output logic                   CH2_RAW_OUTPUT,
    output logic                   CH1_OUTPUT_SIGNAL,
    output logic                   CH2_OUTPUT_SIGNAL,
    output logic                   CH1_INPUT_SIGNAL,
    output logic                   CH2_INPUT_SIGNAL,
    output logic      [CNT_W-1:0]  CH1_COMPARE_VALUE,
    output logic      [CNT_W-1:0]  CH2_COMPARE_VALUE
);

    // index of each asynchronous input in the synchroniser vector
    localparam int P_PIN1_CH1 = 0;
    localparam int P_PIN2_CH1 = 1;
    localparam int P_PIN2_CH2 = 2;
    localparam int P_PIN1_CH2 = 3;
    localparam int P_EXT      = 4;

    // mode control register, one byte per channel
    tcm_mode_s        ch1_mode_q;
    tcm_mode_s        ch2_mode_q;
    tcm_mode_s        ch1_mode_d;
    tcm_mode_s        ch2_mode_d;

    // channel control register
    logic             ch1_enable_q;
    logic             ch2_enable_q;
    logic             ch1_pol_q;
    logic             ch2_pol_q;

    // compare value, active and shadow copies
    logic [CNT_W-1:0] ch1_cmp_q;
    logic [CNT_W-1:0] ch2_cmp_q;
    logic [CNT_W-1:0] ch1_shadow_q;
    logic [CNT_W-1:0] ch2_shadow_q;

    // pin synchronisers and agreed values
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_q;
    logic [PIN_N-1:0] pin_s2_q;
    logic [PIN_N-1:0] pin_s3_q;
    logic [PIN_N-1:0] pin_q;

    // routed inputs
    logic             ch1_in_d;
    logic             ch2_in_d;
    logic             ch1_in_q;
    logic             ch2_in_q;

    // decoded strobes
    logic             wr_mode;
    logic             wr_ch1_cmp;
    logic             wr_ch2_cmp;
    logic             wr_ctrl;
    logic             rd_hit;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] rdata_q;

    // shared timebase carrier
    tcm_count_s       tb;

    // channel results
    logic             ch1_raw;
    logic             ch2_raw;
    logic             ch1_out;
    logic             ch2_out;

    assign tb.counter_value   = COUNTER_VALUE;
    assign tb.count_direction = COUNT_DIRECTION;
    assign tb.overflow_event  = OVERFLOW_EVENT;
    assign tb.trigger_event   = TRIGGER_EVENT;

    // write address decode
    always_comb begin
        wr_mode    = 1'b0;
        wr_ch1_cmp = 1'b0;
        wr_ch2_cmp = 1'b0;
        wr_ctrl    = 1'b0;
        if (!REG_WR) begin
            wr_mode = 1'b0;
        end else if (REG_ADDR == ADDR_MODE_CTRL) begin
            wr_mode = 1'b1;
        end else if (REG_ADDR == ADDR_CH1_CMP) begin
            wr_ch1_cmp = 1'b1;
        end else if (REG_ADDR == ADDR_CH2_CMP) begin
            wr_ch2_cmp = 1'b1;
        end else if (REG_ADDR == ADDR_CH_CTRL) begin
            wr_ctrl = 1'b1;
        end
    end

    // next mode bytes; direction is kept while the channel is enabled
    always_comb begin
        ch1_mode_d = ch1_mode_q;
        ch2_mode_d = ch2_mode_q;
        if (wr_mode) begin
            ch1_mode_d = tcm_mode_s'(REG_WDATA[CH1_FIELD_LSB +: FIELD_W]);
            ch2_mode_d = tcm_mode_s'(REG_WDATA[CH2_FIELD_LSB +: FIELD_W]);
            if (ch1_enable_q) begin
                ch1_mode_d.direction_sel = ch1_mode_q.direction_sel;
            end
            if (ch2_enable_q) begin
                ch2_mode_d.direction_sel = ch2_mode_q.direction_sel;
            end
        end
    end

    // mode control register
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ch1_mode_q <= tcm_mode_s'(MODE_CTRL_RST[CH1_FIELD_LSB +: FIELD_W]);
            ch2_mode_q <= tcm_mode_s'(MODE_CTRL_RST[CH2_FIELD_LSB +: FIELD_W]);
        end else begin
            ch1_mode_q <= ch1_mode_d;
            ch2_mode_q <= ch2_mode_d;
        end
    end

    // channel enables and polarities
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ch1_enable_q <= CH_CTRL_RST[CTRL_CH1_EN_BIT];
            ch2_enable_q <= CH_CTRL_RST[CTRL_CH2_EN_BIT];
            ch1_pol_q    <= CH_CTRL_RST[CTRL_CH1_POL_BIT];
            ch2_pol_q    <= CH_CTRL_RST[CTRL_CH2_POL_BIT];
        end else if (wr_ctrl) begin
            ch1_enable_q <= REG_WDATA[CTRL_CH1_EN_BIT];
            ch2_enable_q <= REG_WDATA[CTRL_CH2_EN_BIT];
            ch1_pol_q    <= REG_WDATA[CTRL_CH1_POL_BIT];
            ch2_pol_q    <= REG_WDATA[CTRL_CH2_POL_BIT];
        end
    end

    // shadow copies always catch the written value
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ch1_shadow_q <= CMP_RST;
            ch2_shadow_q <= CMP_RST;
        end else begin
            if (wr_ch1_cmp) begin
                ch1_shadow_q <= REG_WDATA[CNT_W-1:0];
            end
            if (wr_ch2_cmp) begin
                ch2_shadow_q <= REG_WDATA[CNT_W-1:0];
            end
        end
    end

    // active ch1 compare; a buffered write on an overflow cycle lands
    // in the shadow and waits for the next overflow
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ch1_cmp_q <= CMP_RST;
        end else if (!ch1_mode_q.compare_buffer_en) begin
            if (wr_ch1_cmp) begin
                ch1_cmp_q <= REG_WDATA[CNT_W-1:0];
            end
        end else if (OVERFLOW_EVENT) begin
            ch1_cmp_q <= ch1_shadow_q;
        end
    end

    // active ch2 compare, same scheme
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ch2_cmp_q <= CMP_RST;
        end else if (!ch2_mode_q.compare_buffer_en) begin
            if (wr_ch2_cmp) begin
                ch2_cmp_q <= REG_WDATA[CNT_W-1:0];
            end
        end else if (OVERFLOW_EVENT) begin
            ch2_cmp_q <= ch2_shadow_q;
        end
    end

    assign pin_raw[P_PIN1_CH1] = FILTERED_PIN1_TO_CH1;
    assign pin_raw[P_PIN2_CH1] = FILTERED_PIN2_TO_CH1;
    assign pin_raw[P_PIN2_CH2] = FILTERED_PIN2_TO_CH2;
    assign pin_raw[P_PIN1_CH2] = FILTERED_PIN1_TO_CH2;
    assign pin_raw[P_EXT]      = EXTERNAL_TRIGGER_INPUT;

    // three-stage synchroniser chain; only stage two reads stage one
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // a bit changes only when stages two and three agree
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_q <= '0;
        end else begin
            pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
        end
    end

    // ch1 input routing
    always_comb begin
        case (ch1_mode_q.direction_sel)
            DIR_OWN_PIN:       ch1_in_d = pin_q[P_PIN1_CH1];
            DIR_NEIGHBOUR_PIN: ch1_in_d = pin_q[P_PIN2_CH1];
            // only useful once a trigger source is selected elsewhere
            DIR_INT_TRIGGER:   ch1_in_d = INTERNAL_TRIGGER_INPUT;
            default:           ch1_in_d = 1'b0;
        endcase
    end

    // ch2 input routing
    always_comb begin
        case (ch2_mode_q.direction_sel)
            DIR_OWN_PIN:       ch2_in_d = pin_q[P_PIN2_CH2];
            DIR_NEIGHBOUR_PIN: ch2_in_d = pin_q[P_PIN1_CH2];
            DIR_INT_TRIGGER:   ch2_in_d = INTERNAL_TRIGGER_INPUT;
            default:           ch2_in_d = 1'b0;
        endcase
    end

    // registered input signals for the capture path
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ch1_in_q <= 1'b0;
            ch2_in_q <= 1'b0;
        end else begin
            ch1_in_q <= ch1_in_d;
            ch2_in_q <= ch2_in_d;
        end
    end

    // channel 1 output logic
    tcm_channel u_ch1 (
        .clk           (CLOCK),
        .rst           (RST),
        .mode          (ch1_mode_q),
        .tb            (tb),
        .compare_value (ch1_cmp_q),
        .polarity      (ch1_pol_q),
        .ext_clear     (pin_q[P_EXT]),
        .raw_output    (ch1_raw),
        .output_signal (ch1_out)
    );

    // channel 2 output logic
    tcm_channel u_ch2 (
        .clk           (CLOCK),
        .rst           (RST),
        .mode          (ch2_mode_q),
        .tb            (tb),
        .compare_value (ch2_cmp_q),
        .polarity      (ch2_pol_q),
        .ext_clear     (pin_q[P_EXT]),
        .raw_output    (ch2_raw),
        .output_signal (ch2_out)
    );

    // read address decode; unmapped reads return zero
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        if (REG_ADDR == ADDR_MODE_CTRL) begin
            rd_data[CH1_FIELD_LSB +: FIELD_W] = ch1_mode_q;
            rd_data[CH2_FIELD_LSB +: FIELD_W] = ch2_mode_q;
        end else if (REG_ADDR == ADDR_CH1_CMP) begin
            rd_data = ch1_cmp_q;
        end else if (REG_ADDR == ADDR_CH2_CMP) begin
            rd_data = ch2_cmp_q;
        end else if (REG_ADDR == ADDR_CH_CTRL) begin
            rd_data[CTRL_CH1_EN_BIT]  = ch1_enable_q;
            rd_data[CTRL_CH2_EN_BIT]  = ch2_enable_q;
            rd_data[CTRL_CH1_POL_BIT] = ch1_pol_q;
            rd_data[CTRL_CH2_POL_BIT] = ch2_pol_q;
        end else if (REG_ADDR == ADDR_STATUS) begin
            rd_data[STAT_CH1_RAW_BIT] = ch1_raw;
            rd_data[STAT_CH2_RAW_BIT] = ch2_raw;
            rd_data[STAT_CH1_OUT_BIT] = ch1_out;
            rd_data[STAT_CH2_OUT_BIT] = ch2_out;
            rd_data[STAT_CH1_IN_BIT]  = ch1_in_q;
            rd_data[STAT_CH2_IN_BIT]  = ch2_in_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rdata_q <= '0;
        end else if (REG_RD && rd_hit) begin
            rdata_q <= rd_data;
        end else begin
            rdata_q <= '0;
        end
    end

    assign REG_RDATA         = rdata_q;
    assign CH1_RAW_OUTPUT    = ch1_raw;
    assign CH2_RAW_OUTPUT    = ch2_raw;
    assign CH1_OUTPUT_SIGNAL = ch1_out;
    assign CH2_OUTPUT_SIGNAL = ch2_out;
    assign CH1_INPUT_SIGNAL  = ch1_in_q;
    assign CH2_INPUT_SIGNAL  = ch2_in_q;
    assign CH1_COMPARE_VALUE = ch1_cmp_q;
    assign CH2_COMPARE_VALUE = ch2_cmp_q;

endmodule : tcm_channel_mode_ctrl

// >>> rtl/tcm_pkg.sv
package tcm_pkg;

    // counter and register widths
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CH1_CMP   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CH2_CMP   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CH_CTRL   = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h10;

    // field positions inside the mode control register
    localparam int CH1_FIELD_LSB = 0;
    localparam int CH2_FIELD_LSB = 8;
    localparam int FIELD_W       = 8;
    localparam int DIR_LSB       = 0;

    // field positions inside the channel control register
    localparam int CTRL_CH1_EN_BIT  = 0;
    localparam int CTRL_CH2_EN_BIT  = 1;
    localparam int CTRL_CH1_POL_BIT = 2;
    localparam int CTRL_CH2_POL_BIT = 3;

    // field positions inside the status register
    localparam int STAT_CH1_RAW_BIT = 0;
    localparam int STAT_CH2_RAW_BIT = 1;
    localparam int STAT_CH1_OUT_BIT = 2;
    localparam int STAT_CH2_OUT_BIT = 3;
    localparam int STAT_CH1_IN_BIT  = 4;
    localparam int STAT_CH2_IN_BIT  = 5;

    // reset values
    localparam logic [DATA_W-1:0] MODE_CTRL_RST = 16'h0000;
    localparam logic [CNT_W-1:0]  CMP_RST       = 16'h0000;
    localparam logic [3:0]        CH_CTRL_RST   = 4'h0;

    // number of synchronised pin inputs
    localparam int PIN_N = 5;

    typedef enum logic [1:0] {
        DIR_OUTPUT        = 2'b00,
        DIR_OWN_PIN       = 2'b01,
        DIR_NEIGHBOUR_PIN = 2'b10,
        DIR_INT_TRIGGER   = 2'b11
    } tcm_dir_e;

    typedef enum logic [2:0] {
        OC_DISCONNECT   = 3'b000,
        OC_HIGH_ON_MATCH = 3'b001,
        OC_LOW_ON_MATCH = 3'b010,
        OC_TOGGLE       = 3'b011,
        OC_FORCE_LOW    = 3'b100,
        OC_FORCE_HIGH   = 3'b101,
        OC_PWM_A        = 3'b110,
        OC_PWM_B        = 3'b111
    } tcm_oc_e;

    // one channel's byte of the mode control register, msb first
    typedef struct packed {
        logic     ext_clear_en;
        tcm_oc_e  out_ctrl_code;
        logic     compare_buffer_en;
        logic     fast_trigger_out_en;
        tcm_dir_e direction_sel;
    } tcm_mode_s;

    // timebase signals shared by both channels
    typedef struct packed {
        logic [CNT_W-1:0] counter_value;
        logic             count_direction;
        logic             overflow_event;
        logic             trigger_event;
    } tcm_count_s;

endpackage : tcm_pkg

// >>> rtl/tcm_channel.sv
module tcm_channel
    import tcm_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire tcm_mode_s        mode,
    input  wire tcm_count_s       tb,
    input  wire logic [CNT_W-1:0] compare_value,
    input  wire logic             polarity,
    input  wire logic             ext_clear,
    output logic                  raw_output,
    output logic                  output_signal
);

    logic raw_q;
    logic out_q;
    logic match_q;
    logic match;
    logic is_output;
    logic pwm_mode;
    logic cmp_gt;
    logic cmp_lt;

    assign match     = (tb.counter_value == compare_value);
    assign cmp_gt    = (compare_value > tb.counter_value);
    assign cmp_lt    = (compare_value < tb.counter_value);
    assign is_output = (mode.direction_sel == DIR_OUTPUT);
    assign pwm_mode  = (mode.out_ctrl_code == OC_PWM_A) || (mode.out_ctrl_code == OC_PWM_B);

    // match edge, so a stalled counter toggles only once
    always_ff @(posedge clk) begin
        if (rst) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // raw output; output-mode bits count only while the channel is an output
    always_ff @(posedge clk) begin
        if (rst) begin
            raw_q <= 1'b0;
        end else if (!is_output) begin
            raw_q <= 1'b0;
        end else if (mode.ext_clear_en && ext_clear) begin
            raw_q <= 1'b0;
        end else if (pwm_mode && mode.fast_trigger_out_en && tb.trigger_event) begin
            raw_q <= 1'b1;
        end else begin
            case (mode.out_ctrl_code)
                OC_HIGH_ON_MATCH: if (match && !match_q) raw_q <= 1'b1;
                OC_LOW_ON_MATCH:  if (match && !match_q) raw_q <= 1'b0;
                OC_TOGGLE:        if (match && !match_q) raw_q <= !raw_q;
                OC_FORCE_LOW:     raw_q <= 1'b0;
                OC_FORCE_HIGH:    raw_q <= 1'b1;
                OC_PWM_A:         raw_q <= tb.count_direction ? !cmp_lt : cmp_gt;
                OC_PWM_B:         raw_q <= tb.count_direction ? cmp_gt : !cmp_gt;
                default:          raw_q <= raw_q;
            endcase
        end
    end

    // pin signal: an input direction or code 000 cuts it off, other codes follow raw with polarity
    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (!is_output || mode.out_ctrl_code == OC_DISCONNECT) begin
            out_q <= 1'b0;
        end else begin
            out_q <= raw_q ^ polarity;
        end
    end

    assign raw_output    = raw_q;
    assign output_signal = out_q;

endmodule : tcm_channel

// >>> bench/tcm_channel_mode_ctrl_chk.sv
module tcm_channel_mode_ctrl_chk
    import tcm_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RST,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire logic [CNT_W-1:0]  COUNTER_VALUE,
    input wire logic              COUNT_DIRECTION,
    input wire logic              OVERFLOW_EVENT,
    input wire logic              TRIGGER_EVENT,
    input wire logic              CH1_RAW_OUTPUT,
    input wire logic              CH1_OUTPUT_SIGNAL,
    input wire logic [CNT_W-1:0]  CH1_COMPARE_VALUE
);
    logic [DATA_W-1:0] mode_q;
    logic [3:0]        ctrl_q;
    logic              match_q;
    logic              dir0;
    logic              ecl;
    logic [2:0]        code;
    logic              gt;
    logic              pwm_exp;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // decoded channel 1 fields; pwm level worked out from count direction
    assign dir0    = (mode_q[1:0] == 2'b00);
    assign ecl     = mode_q[7];
    assign code    = mode_q[6:4];
    assign gt      = CH1_COMPARE_VALUE > COUNTER_VALUE;
    assign pwm_exp = code[0] ? (COUNT_DIRECTION ? gt : !gt)
                   : (COUNT_DIRECTION ? (CH1_COMPARE_VALUE >= COUNTER_VALUE) : gt);

    // mirror of the mode register; a running channel keeps its direction
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mode_q <= MODE_CTRL_RST;
        end else if (REG_WR && REG_ADDR == ADDR_MODE_CTRL) begin
            mode_q[15:10] <= REG_WDATA[15:10];
            mode_q[7:2]   <= REG_WDATA[7:2];
            if (!ctrl_q[CTRL_CH1_EN_BIT]) begin
                mode_q[1:0] <= REG_WDATA[1:0];
            end
            if (!ctrl_q[CTRL_CH2_EN_BIT]) begin
                mode_q[9:8] <= REG_WDATA[9:8];
            end
        end
    end

    // mirror of enables and polarity
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl_q <= CH_CTRL_RST;
        end else if (REG_WR && REG_ADDR == ADDR_CH_CTRL) begin
            ctrl_q <= REG_WDATA[3:0];
        end
    end

    // previous match, so only the first cycle of a match counts
    always_ff @(posedge CLOCK) begin
        match_q <= RST ? 1'b0 : (COUNTER_VALUE == CH1_COMPARE_VALUE);
    end

    chk_mode_readback : assert property (
        REG_RD && REG_ADDR == ADDR_MODE_CTRL |=> REG_RDATA == $past(mode_q))
        else $error("mode register read back differs");
    chk_input_quiet : assert property (
        (!dir0)[*2] |=> !CH1_RAW_OUTPUT && !CH1_OUTPUT_SIGNAL)
        else $error("input channel drives its output");
    chk_force_level : assert property (
        dir0 && !ecl && code[2:1] == 2'b10 |=> CH1_RAW_OUTPUT == $past(code[0]))
        else $error("forced level wrong");
    chk_match_set_clear : assert property (
        dir0 && !ecl && (code == 3'b001 || code == 3'b010)
        && COUNTER_VALUE == CH1_COMPARE_VALUE && !match_q
        |=> CH1_RAW_OUTPUT == $past(code[0]))
        else $error("match did not set or clear raw");
    chk_match_toggle : assert property (
        dir0 && !ecl && code == 3'b011 && COUNTER_VALUE == CH1_COMPARE_VALUE && !match_q
        |=> CH1_RAW_OUTPUT != $past(CH1_RAW_OUTPUT))
        else $error("match did not toggle raw");
    chk_pwm_level : assert property (
        dir0 && !ecl && code[2:1] == 2'b11 && !(mode_q[2] && TRIGGER_EVENT)
        |=> CH1_RAW_OUTPUT == $past(pwm_exp))
        else $error("pwm level wrong");
    chk_fast_trigger : assert property (
        dir0 && !ecl && code[2:1] == 2'b11 && mode_q[2] && TRIGGER_EVENT |=> CH1_RAW_OUTPUT)
        else $error("trigger did not drive output at once");
    chk_output_follow : assert property (
        dir0 |=> CH1_OUTPUT_SIGNAL == ($past(code) != 3'b000
        && ($past(CH1_RAW_OUTPUT) ^ $past(ctrl_q[CTRL_CH1_POL_BIT]))))
        else $error("output does not follow raw and polarity");
    chk_unbuf_write : assert property (
        REG_WR && REG_ADDR == ADDR_CH1_CMP && !mode_q[3]
        |=> CH1_COMPARE_VALUE == $past(REG_WDATA))
        else $error("unbuffered compare write late");
    chk_buf_hold : assert property (
        mode_q[3] && !OVERFLOW_EVENT |=> $stable(CH1_COMPARE_VALUE))
        else $error("buffered compare changed without overflow");

    cov_toggle : cover property (code == 3'b011 && COUNTER_VALUE == CH1_COMPARE_VALUE);
    cov_fast : cover property (code == 3'b110 && mode_q[2] && TRIGGER_EVENT);
    cov_buf_load : cover property (mode_q[3] && OVERFLOW_EVENT);
    cov_dir_lock : cover property (REG_WR && REG_ADDR == ADDR_MODE_CTRL && ctrl_q[0]);
endmodule : tcm_channel_mode_ctrl_chk

bind tcm_channel_mode_ctrl tcm_channel_mode_ctrl_chk u_chk (
    .CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .COUNTER_VALUE(COUNTER_VALUE), .COUNT_DIRECTION(COUNT_DIRECTION),
    .OVERFLOW_EVENT(OVERFLOW_EVENT), .TRIGGER_EVENT(TRIGGER_EVENT),
    .CH1_RAW_OUTPUT(CH1_RAW_OUTPUT), .CH1_OUTPUT_SIGNAL(CH1_OUTPUT_SIGNAL),
    .CH1_COMPARE_VALUE(CH1_COMPARE_VALUE)
);

// >>> bench/tcm_channel_mode_ctrl_tb_top.sv
module tcm_channel_mode_ctrl_tb_top
    import tcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clock, rst, reg_wr, reg_rd, cnt_dir, ovf, trig, external_trigger_input;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [CNT_W-1:0]  cnt, cmp1, cmp2;
    logic [4:0]        src, tmp;
    logic              raw1, raw2, out1, out2, in1, in2, gt, lt, e;
    int                bad_count = 0;
    int                checks_done = 0;
    int                s1[3] = '{0, 1, 4};
    int                s2[3] = '{2, 3, 4};
    logic [2:0]        mc[4] = '{3'b001, 3'b010, 3'b011, 3'b011};
    logic              me[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    tcm_channel_mode_ctrl DUT (
        .CLOCK(clock), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .COUNTER_VALUE(cnt), .COUNT_DIRECTION(cnt_dir), .OVERFLOW_EVENT(ovf),
        .TRIGGER_EVENT(trig), .INTERNAL_TRIGGER_INPUT(src[4]),
        .FILTERED_PIN1_TO_CH1(src[0]), .FILTERED_PIN2_TO_CH1(src[1]),
        .FILTERED_PIN2_TO_CH2(src[2]), .FILTERED_PIN1_TO_CH2(src[3]),
        .EXTERNAL_TRIGGER_INPUT(external_trigger_input), .CH1_RAW_OUTPUT(raw1), .CH2_RAW_OUTPUT(raw2),
        .CH1_OUTPUT_SIGNAL(out1), .CH2_OUTPUT_SIGNAL(out2), .CH1_INPUT_SIGNAL(in1),
        .CH2_INPUT_SIGNAL(in2), .CH1_COMPARE_VALUE(cmp1), .CH2_COMPARE_VALUE(cmp2)
    );

    // free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic close_out();
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic cmp_w(input logic [15:0] g, input logic [15:0] x);
        checks_done++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: word %h, expected %h", $time, g, x);
        end
    endtask : cmp_w

    task automatic cmp_b(input logic g, input logic x);
        checks_done++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: bit %b, expected %b", $time, g, x);
        end
    endtask : cmp_b

    // waits leave 1 ns so edge updates have landed before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        cmp_w(reg_rdata, x);
    endtask : rd

    // one-cycle event pulse: trigger when t is set, overflow otherwise
    task automatic pulse(input logic t);
        @(posedge clock);
        trig <= t;
        ovf  <= !t;
        @(posedge clock);
        trig <= 1'b0;
        ovf  <= 1'b0;
        #1;
    endtask : pulse

    // walks the counter across the compare value once, then parks it at 7
    task automatic sweep();
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            cnt <= 16'(i);
        end
        cyc(2);
    endtask : sweep

    // hang guard at 10000 cycles, well above the expected run of a few hundred cycles
    initial begin
        #500000;
        bad_count++;
        close_out();
    end

    initial begin
        {rst, reg_wr, reg_rd, cnt_dir, ovf, trig, external_trigger_input} = 7'h01 << 6;
        {reg_addr, reg_wdata, cnt, src} = '0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(8'(a * 4), 16'h0000);
        for (int d = 1; d < 4; d++) begin
            wr(ADDR_MODE_CTRL, {2{6'h00, 2'(d)}});
            for (int v = 0; v < 2; v++) begin
                tmp = {5{~v[0]}};
                tmp[s1[d-1]] = v[0];
                tmp[s2[d-1]] = v[0];
                @(posedge clock);
                src <= tmp;
                cyc(8);
                cmp_b(in1, v[0]);
                cmp_b(in2, v[0]);
                cmp_b(raw1, 1'b0);
            end
        end
        wr(ADDR_CH_CTRL, 16'h0003);
        wr(ADDR_MODE_CTRL, 16'h0000);
        rd(ADDR_MODE_CTRL, 16'h0303);
        wr(ADDR_CH_CTRL, 16'h0000);
        wr(ADDR_MODE_CTRL, 16'hd6a4);
        rd(ADDR_MODE_CTRL, 16'hd6a4);
        for (int p = 0; p < 2; p++) begin
            for (int c = 4; c < 6; c++) begin
                wr(ADDR_CH_CTRL, {12'h000, p[0], p[0], 2'b00});
                wr(ADDR_MODE_CTRL, {2{1'b0, 3'(c), 4'h0}});
                cyc(3);
                cmp_b(raw1, c[0]);
                cmp_b(raw2, c[0]);
                cmp_b(out1, c[0] ^ p[0]);
                cmp_b(out2, c[0] ^ p[0]);
            end
        end
        wr(ADDR_MODE_CTRL, 16'h0000);
        cyc(3);
        cmp_b(out1, 1'b0);
        cmp_b(out2, 1'b0);
        wr(ADDR_CH_CTRL, 16'h0000);
        wr(ADDR_CH1_CMP, 16'h0005);
        cmp_w(cmp1, 16'h0005);
        wr(ADDR_MODE_CTRL, 16'h0040);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MODE_CTRL, {9'h000, mc[i], 4'h0});
            sweep();
            cmp_b(raw1, me[i]);
        end
        for (int c = 6; c < 8; c++) begin
            for (int d = 0; d < 2; d++) begin
                for (int n = 4; n < 7; n++) begin
                    wr(ADDR_MODE_CTRL, {9'h000, 3'(c), 4'h0});
                    @(posedge clock);
                    cnt     <= 16'(n);
                    cnt_dir <= d[0];
                    cyc(3);
                    gt = 5 > n;
                    lt = 5 < n;
                    e  = (c == 6) ? (d[0] ? !lt : gt) : (d[0] ? gt : !gt);
                    cmp_b(raw1, e);
                end
            end
        end
        wr(ADDR_MODE_CTRL, 16'h0064);
        @(posedge clock);
        cnt     <= 16'h0009;
        cnt_dir <= 1'b0;
        cyc(3);
        pulse(1'b1);
        cmp_b(raw1, 1'b1);
        wr(ADDR_MODE_CTRL, 16'h0060);
        pulse(1'b1);
        cmp_b(raw1, 1'b0);
        wr(ADDR_MODE_CTRL, 16'h0068);
        wr(ADDR_CH1_CMP, 16'h0009);
        cyc(2);
        cmp_w(cmp1, 16'h0005);
        rd(ADDR_CH1_CMP, 16'h0005);
        pulse(1'b0);
        cmp_w(cmp1, 16'h0009);
        wr(ADDR_CH2_CMP, 16'h1234);
        cmp_w(cmp2, 16'h1234);
        // ext clear only bites when its enable is set; the synchroniser takes 4 edges, raw clears on the 5th
        wr(ADDR_MODE_CTRL, 16'h00d0);
        @(posedge clock);
        external_trigger_input <= 1'b1;
        cyc(8);
        cmp_b(raw1, 1'b0);
        wr(ADDR_MODE_CTRL, 16'h0050);
        cyc(3);
        cmp_b(raw1, 1'b1);
        rd(ADDR_STATUS, 16'h0007);
        close_out();
    end
endmodule : tcm_channel_mode_ctrl_tb_top
